/* File: design/ltc_pkg.sv */
// Package of constants and types for the line transmit control block
// How it works
// R01 - All-ones insert bit 2 set: input data dropped, unframed all-ones sent instead.
// R02 - Edge select 0 samples rails on clock falling edge; 1 on rising edge.
// R03 - Software writes build-out 0 for cable up to 225 feet, else 1.
// R04 - Build-out bit 0 ignored at E3; shapes pulses only at DS3 and STS-1.
// R05 - Every channel keeps its own sample edge selection, independent of others.
// R06 - Reserved control bits read as zero and writes to them do nothing.
package ltc_pkg;
  // Register offsets within a channel page; the page is the address high nibble
  localparam logic [3:0] LTC_TX_CTRL_OFS = 4'h4;
  localparam logic [3:0] LTC_RX_CTRL_OFS = 4'h5;
  localparam int LTC_CH_POS = 4;
  // Transmit control field positions
  localparam int LTC_BUILDOUT_BIT = 0;
  localparam int LTC_EDGE_BIT = 1;
  localparam int LTC_ALL_ONES_BIT = 2;
  localparam int LTC_PRBS_ERR_BIT = 4;
  localparam int LTC_DRIVE_MON_BIT = 5;
  // Writable bit masks; the rest are reserved
  localparam logic [7:0] LTC_TX_WMASK = 8'h37;
  localparam logic [7:0] LTC_RX_WMASK = 8'h3F;
  // Values after reset
  localparam logic [7:0] LTC_TX_RESET = 8'h00;
  localparam logic [7:0] LTC_RX_RESET = 8'h00;
  localparam logic [7:0] LTC_RDATA_RESET = 8'h00;
  // Defaults for structural parameters
  localparam int LTC_NCH = 12;
  localparam int LTC_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {LTC_RATE_E3, LTC_RATE_DS3, LTC_RATE_STS1} ltc_rate_e;

  typedef struct packed {
    logic pos;
    logic neg;
  } ltc_rail_s;
endpackage

/* File: design/ltc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ltc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  // Honest flags from the occupancy count
  assign in_ready = (count_r != CNT_FULL);
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule

/* File: design/ltc_top.sv */
// Per-channel transmit control registers and transmit rail capture path
`timescale 1ns/10ps
module ltc_top #(
  parameter int NCH = ltc_pkg::LTC_NCH,
  parameter int FIFO_DEPTH = ltc_pkg::LTC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire ltc_pkg::ltc_rate_e rate [NCH],
  input wire logic [NCH-1:0] tx_line_clock_in,
  input wire logic [NCH-1:0] tx_positive_rail_in,
  input wire logic [NCH-1:0] tx_negative_rail_in,
  output logic [NCH-1:0] tx_accept_ready,
  output logic [NCH-1:0] line_valid,
  input wire logic [NCH-1:0] line_ready,
  output ltc_pkg::ltc_rail_s line_data [NCH],
  output logic [NCH-1:0] buildout_active,
  output logic [NCH-1:0] drive_monitor_internal,
  output logic [NCH-1:0] prbs_error_insert,
  output logic [7:0] rx_ctrl [NCH]
);
  import ltc_pkg::*;

  // Channel data path, in order of flow:
  //   line clock and rails, two-stage synchroniser, edge detector,
  //   sample on the selected edge, FIFO, output register, consumer.
  // The line clock is sampled rather than used as a clock, so each of its
  // levels must last longer than one clk cycle or edges are lost.
  // Rails pass the same two stages as the clock, so the pair taken at a detected
  // edge is the pair that stood on the pins when that edge arrived.
  // In all-ones mode the FIFO keeps draining, so no stale system data waits
  // to leak onto the line once the mode is turned off again.
  // Reserved control bits are masked on write, so they always read back zero.

  // Control bytes of every channel, gathered for read-back
  wire [NCH-1:0][7:0] tx_bank;
  wire [NCH-1:0][7:0] rx_bank;

  // Address names a mapped channel page and the given register offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [3:0] ofs);
    return (32'(a[7:LTC_CH_POS]) < NCH) && (a[LTC_CH_POS-1:0] == ofs);
  endfunction

  // Byte of the addressed channel; pages past the last channel give zero
  function automatic logic [7:0] pick_ctrl(input logic [NCH-1:0][7:0] bank,
      input logic [3:0] ch);
    logic [7:0] byte_v;
    byte_v = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (32'(ch) == i) begin
        byte_v = bank[i];
      end
    end
    return byte_v;
  endfunction

  // Edge strobe chosen by the sample edge select bit
  function automatic logic pick_edge(input logic on_rise, input logic cur, input logic old);
    return on_rise ? (cur && !old) : (!cur && old);
  endfunction

  // One mark of the all-ones pattern; the phase picks the rail so marks alternate
  function automatic ltc_rail_s mark_word(input logic phase);
    ltc_rail_s w;
    w.pos = !phase;
    w.neg = phase;
    return w;
  endfunction

  // Address decode: high nibble picks the channel page, low nibble the register
  wire [3:0] ch_sel = addr[7:LTC_CH_POS];
  wire tx_hit = reg_hit(addr, LTC_TX_CTRL_OFS);
  wire rx_hit = reg_hit(addr, LTC_RX_CTRL_OFS);
  wire tx_wr = wr_en && tx_hit;
  wire rx_wr = wr_en && rx_hit;

  // Read selection; unmapped addresses and reserved bits read zero
  wire [7:0] tx_rd_byte = pick_ctrl(tx_bank, ch_sel);
  wire [7:0] rx_rd_byte = pick_ctrl(rx_bank, ch_sel);
  wire [7:0] rd_sel = tx_hit ? tx_rd_byte : (rx_hit ? rx_rd_byte : 8'h00); // [R06]

  // Read data register; holds between reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= LTC_RDATA_RESET;
    end else if (rd_en) begin
      rdata <= rd_sel;
    end
  end

  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    logic [7:0] tx_ctrl_r;
    logic [7:0] rx_ctrl_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic clk_prev_r;
    logic mark_phase_r;
    logic out_vld_r;
    ltc_rail_s out_data_r;
    logic fifo_vld;
    logic fifo_rdy;
    ltc_rail_s fifo_data;
    ltc_rail_s cap;
    ltc_rail_s ones_word;

    // Write strobes for this channel's page only
    wire page_me = (32'(ch_sel) == g);
    wire tx_wr_me = tx_wr && page_me; // [R05]
    wire rx_wr_me = rx_wr && page_me;

    // Transmit control byte; reserved bits are never stored
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        tx_ctrl_r <= LTC_TX_RESET;
      end else if (tx_wr_me) begin
        tx_ctrl_r <= wdata & LTC_TX_WMASK; // [R06] [R05]
      end
    end

    // Receive control byte; stored and exported, no behaviour here
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rx_ctrl_r <= LTC_RX_RESET;
      end else if (rx_wr_me) begin
        rx_ctrl_r <= wdata & LTC_RX_WMASK; // [R06]
      end
    end

    // Bytes gathered for the shared read path
    assign tx_bank[g] = tx_ctrl_r;
    assign rx_bank[g] = rx_ctrl_r;

    // Control decode for this channel
    wire all_ones = tx_ctrl_r[LTC_ALL_ONES_BIT];
    wire edge_rise = tx_ctrl_r[LTC_EDGE_BIT];
    wire buildout_bit = tx_ctrl_r[LTC_BUILDOUT_BIT];
    wire rate_e3 = (rate[g] == LTC_RATE_E3);
    assign buildout_active[g] = buildout_bit && !rate_e3; // [R04]
    assign drive_monitor_internal[g] = tx_ctrl_r[LTC_DRIVE_MON_BIT];
    assign prbs_error_insert[g] = tx_ctrl_r[LTC_PRBS_ERR_BIT];
    assign rx_ctrl[g] = rx_ctrl_r;

    // First synchroniser stage for clock and rails
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync1_r <= 3'h0;
      end else begin
        sync1_r <= {tx_line_clock_in[g], tx_positive_rail_in[g], tx_negative_rail_in[g]};
      end
    end

    // Second synchroniser stage; only this stage is read by logic
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync2_r <= 3'h0;
      end else begin
        sync2_r <= sync1_r;
      end
    end

    // Previous clock level, reset to the idle low level so no false edge follows reset
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        clk_prev_r <= 1'b0;
      end else begin
        clk_prev_r <= sync2_r[2];
      end
    end

    // Selected edge of the synchronised line clock and the rail pair it captures
    wire line_clk_now = sync2_r[2];
    wire sample = pick_edge(edge_rise, line_clk_now, clk_prev_r); // [R02] [R05]
    assign cap = '{pos: sync2_r[1], neg: sync2_r[0]};

    // Elastic store between line edges and the consumer; a full store drops samples
    ltc_fifo #(
      .WIDTH($bits(ltc_rail_s)),
      .DEPTH(FIFO_DEPTH)
    ) u_ltc_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(sample),
      .in_ready(tx_accept_ready[g]),
      .in_data(cap),
      .out_valid(fifo_vld),
      .out_ready(fifo_rdy),
      .out_data(fifo_data)
    );

    // Output stage: room when empty or when the consumer takes the word
    wire out_room = !out_vld_r || line_ready[g];
    wire load = out_room && (all_ones || fifo_vld);
    assign fifo_rdy = out_room || all_ones; // [R01] Drain and discard
    assign ones_word = mark_word(mark_phase_r);

    // Output word register
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        out_data_r <= '0;
      end else if (load) begin
        out_data_r <= all_ones ? ones_word : fifo_data; // [R01]
      end
    end

    // Output valid: set on load, cleared once the consumer takes the word
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        out_vld_r <= 1'b0;
      end else if (load) begin
        out_vld_r <= 1'b1;
      end else if (line_ready[g]) begin
        out_vld_r <= 1'b0;
      end
    end

    // Mark phase advances with every all-ones word handed over
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mark_phase_r <= 1'b0;
      end else if (load && all_ones) begin
        mark_phase_r <= !mark_phase_r; // Alternating marks [R01]
      end
    end

    // Outputs straight from the registers
    assign line_valid[g] = out_vld_r;
    assign line_data[g] = out_data_r;
  end
endmodule

/* File: tb/ltc_monitor.sv */
// Port checker for the line transmit control block
`timescale 1ns/10ps
module ltc_monitor #(parameter int NCH = 2) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire ltc_pkg::ltc_rate_e rate [NCH],
  input wire logic [NCH-1:0] line_valid,
  input wire logic [NCH-1:0] line_ready,
  input wire ltc_pkg::ltc_rail_s line_data [NCH],
  input wire logic [NCH-1:0] buildout_active
);
  import ltc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Register read-back and output relations
  property p_unmapped_zero;
    rd_en && addr[3:1] != 3'h2 |=> rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
  property p_tx_reserved;
    rd_en && addr[3:0] == 4'h4 |=> (rdata & 8'hC8) == 8'h00;
  endproperty
  a_tx_reserved: assert property (p_tx_reserved) else $error("tx reserved set");
  property p_rx_reserved;
    rd_en && addr[3:0] == 4'h5 |=> rdata[7:6] == 2'b00;
  endproperty
  a_rx_reserved: assert property (p_rx_reserved) else $error("rx reserved set");
  property p_e3_no_buildout;
    rate[0] == LTC_RATE_E3 |-> !buildout_active[0];
  endproperty
  a_e3_no_buildout: assert property (p_e3_no_buildout) else $error("buildout at E3");
  property p_word_holds;
    line_valid[0] && !line_ready[0] |=> line_valid[0] && $stable(line_data[0]);
  endproperty
  a_word_holds: assert property (p_word_holds) else $error("word dropped");
endmodule

/* File: tb/ltc_framer_model.sv */
// Behavioural framer driving one transmit channel
`timescale 1ns/10ps
module ltc_framer_model (
  output logic line_clk = 1'b0,
  output logic pos = 1'b0,
  output logic neg = 1'b1
);
  // One symbol: r stands at the rising edge, f at the falling edge
  task automatic send(input logic [1:0] r, input logic [1:0] f);
    {pos, neg} = r;
    #20 line_clk = 1'b1;
    #20 {pos, neg} = f;
    #20 line_clk = 1'b0;
    #20 {pos, neg} = ~f; // Released rails keep no stale value
  endtask
endmodule

/* File: tb/line_transmit_control_tb.sv */
// Self-checking bench for the line transmit control block
`timescale 1ns/10ps
module line_transmit_control_tb;
  import ltc_pkg::*;
  localparam int NCH = 2;
  logic clk, rst, wr_en, rd_en, m_clk, m_pos, m_neg;
  logic [7:0] addr, wdata, rdata;
  ltc_rate_e rate [NCH];
  logic [NCH-1:0] acc, lvalid, lready, bo, dmon, perr;
  logic [7:0] rxc [NCH];
  ltc_rail_s ldata [NCH];
  int miscompares = 0, total_checks = 0;
  logic [1:0] got [$];
  logic [23:0] rows [5] = '{24'h04FF37, 24'h05FF3F, 24'h140202, 24'h07FF00, 24'h24FF00};
  ltc_framer_model u_ltc_framer_model (.line_clk(m_clk), .pos(m_pos), .neg(m_neg));
  ltc_top #(.NCH(NCH)) u_ltc_top (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .rate(rate),
    .tx_line_clock_in({1'b0, m_clk}), .tx_positive_rail_in({1'b0, m_pos}),
    .tx_negative_rail_in({1'b0, m_neg}), .tx_accept_ready(acc), .line_valid(lvalid),
    .line_ready(lready), .line_data(ldata), .buildout_active(bo),
    .drive_monitor_internal(dmon), .prbs_error_insert(perr), .rx_ctrl(rxc));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Collect every word handed over on channel 0
  always @(posedge clk) if (lvalid[0] === 1'b1 && lready[0] === 1'b1) got.push_back(ldata[0]);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr_en} = {a, d, 1'b1};
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {addr, rd_en} = {a, 1'b1};
    @(negedge clk);
    rd_en = 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {rst, addr, wdata, wr_en, rd_en, lready} = {1'b1, 18'h0, 2'b11};
    rate = '{LTC_RATE_DS3, LTC_RATE_DS3};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check(rdata, LTC_RDATA_RESET);
    check({6'h0, acc}, 8'h03);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    rd(8'h04, 8'h37);
    check({6'h0, dmon}, 8'h01);
    check({6'h0, perr}, 8'h01);
    check(rxc[0], 8'h3F);
    check(rxc[1], 8'h00);
    check({7'h0, bo[0]}, 8'h01);
    rate[0] = LTC_RATE_E3;
    @(negedge clk);
    check({7'h0, bo[0]}, 8'h00);
    wr(8'h14, 8'h03); // Channel 1 cable longer than the short limit
    check({6'h0, bo}, 8'h02);
    got.delete();
    repeat (2) u_ltc_framer_model.send(2'b00, 2'b00);
    check({6'h0, got[0] ^ got[1]}, 8'h03);
    check({6'h0, got[2] | got[3]}, 8'h03);
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, {6'h0, m[0], 1'b0});
      repeat (2) @(negedge clk);
      got.delete();
      u_ltc_framer_model.send(2'b10, 2'b01);
      u_ltc_framer_model.send(2'b00, 2'b11);
      repeat (4) @(negedge clk);
      check({4'h0, got[0], got[1]}, m ? 8'h08 : 8'h07);
      check(8'(got.size()), 8'h02);
    end
    got.delete();
    lready = 2'b00;
    repeat (10) u_ltc_framer_model.send(2'b10, 2'b10);
    check({7'h0, acc[0]}, 8'h00);
    lready = 2'b11;
    repeat (20) @(negedge clk);
    check({6'h0, acc[0], lvalid[0]}, 8'h02);
    check(8'(got.size()), 8'(LTC_FIFO_DEPTH + 1));
    check({6'h0, got[0]}, 8'h02);
    // Reset in mid-run returns the ready and valid flags and channel 0 transmit control to their reset values
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({4'h0, acc, lvalid}, 8'h0C);
    rd(8'h04, LTC_TX_RESET);
    report_and_stop();
  end
endmodule
bind ltc_top ltc_monitor #(.NCH(NCH)) u_ltc_monitor (.clk(clk), .rst(rst), .addr(addr),
  .rd_en(rd_en), .rdata(rdata), .rate(rate), .line_valid(line_valid),
  .line_ready(line_ready), .line_data(line_data), .buildout_active(buildout_active));
